// ### clh_cfg.svh
`ifndef CLH_CFG_SVH
`define CLH_CFG_SVH

// ==========================================
// geometry of the lookup array and its pins
`define CLH_DEPTH 4096
`define CLH_IDX_W 12
`define CLH_DATA_W 32
`define CLH_WORD_W 64
`define CLH_AC_W 12
`define CLH_PAGE_W 4
`define CLH_CODE_W 4

// ==========================================
// reset values and the all-ones miss index
`define CLH_IDX_RESET 12'h000
`define CLH_IDX_ALL_ONES 12'hfff
`define CLH_WORD_RESET 64'h0000_0000_0000_0000
`define CLH_DATA_RESET 32'h0000_0000
`define CLH_INSTR_RESET 12'h000

// ==========================================
// control codes, meaning depends on write direction
`define CLH_CODE_COMPARAND 4'h0
`define CLH_CODE_SEARCH 4'h1
`define CLH_CODE_FREE 4'h2
`define CLH_CODE_DELETE 4'h3
`define CLH_CODE_AT_MATCH 4'h4

`endif

// ### clh_pkg.sv
`default_nettype none
`include "clh_cfg.svh"

package clh_pkg;

    // ==========================================
    // decoded operation of one host cycle
    typedef enum logic [3:0] {
        CLH_OP_NONE = 4'b0000,
        CLH_OP_MEM_WR = 4'b0001,
        CLH_OP_MEM_RD = 4'b0010,
        CLH_OP_CMP_LOAD = 4'b0011,
        CLH_OP_CMP_READ = 4'b0100,
        CLH_OP_COMPARE = 4'b0101,
        CLH_OP_WR_FREE = 4'b0110,
        CLH_OP_DEL_MATCH = 4'b0111,
        CLH_OP_WR_MATCH = 4'b1000,
        CLH_OP_RD_MATCH = 4'b1001,
        CLH_OP_SW_INSTR = 4'b1010
    } clh_op_t;

    // ==========================================
    // inputs sampled at the strobe falling edge
    typedef struct packed {
        logic wr_n;
        logic seg;
        logic vb_n;
        logic av_n;
        logic [`CLH_AC_W-1:0] ac;
        logic [`CLH_DATA_W-1:0] data;
    } clh_cycle_t;

    // command into the array
    typedef struct packed {
        logic [`CLH_IDX_W-1:0] addr;
        logic we_lo;
        logic we_hi;
        logic [`CLH_WORD_W-1:0] wdata;
        logic val_we;
        logic val;
        logic rd;
    } clh_arr_cmd_t;

endpackage : clh_pkg

`default_nettype wire

// ### clh_array.sv
`default_nettype none
`include "clh_cfg.svh"

module clh_array (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // command and search key
    input wire clh_pkg::clh_arr_cmd_t cmd,
    input wire logic [`CLH_WORD_W-1:0] comparand,
    // read port
    output logic [`CLH_WORD_W-1:0] rdata,
    output logic rvalid,
    // search results, combinational
    output logic match_hit,
    output logic [`CLH_IDX_W-1:0] match_idx,
    output logic free_hit,
    output logic [`CLH_IDX_W-1:0] free_idx
);
    import clh_pkg::*;

    logic [`CLH_WORD_W-1:0] mem [0:`CLH_DEPTH-1];
    logic [`CLH_DEPTH-1:0] valid;

    // ==========================================
    // word storage, no reset: contents mean nothing until valid
    always_ff @(posedge core_clk) begin
        if (clk_en && cmd.we_lo) begin
            mem[cmd.addr][31:0] <= cmd.wdata[31:0];
        end
        if (clk_en && cmd.we_hi) begin
            mem[cmd.addr][63:32] <= cmd.wdata[63:32];
        end
    end

    // validity bits start empty
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid <= '0;
        end else if (clk_en && cmd.val_we) begin
            valid[cmd.addr] <= cmd.val;
        end
    end

    // registered read, one cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `CLH_WORD_RESET;
            rvalid <= 1'b0;
        end else if (clk_en && cmd.rd) begin
            rdata <= mem[cmd.addr];
            rvalid <= valid[cmd.addr];
        end
    end

    // ==========================================
    // priority search: lowest index wins, so scan downward
    always_comb begin
        match_hit = 1'b0;
        match_idx = `CLH_IDX_RESET;
        free_hit = 1'b0;
        free_idx = `CLH_IDX_RESET;
        for (int i = `CLH_DEPTH - 1; i >= 0; i--) begin
            if (valid[i] && mem[i] == comparand) begin
                match_hit = 1'b1;
                match_idx = `CLH_IDX_W'(i);
            end
            if (!valid[i]) begin
                free_hit = 1'b1;
                free_idx = `CLH_IDX_W'(i);
            end
        end
    end

endmodule : clh_array

`default_nettype wire

// ### clh_host_port.sv
// Behaviour
// - strobe high: data lines float, device idle
// - write-direction low takes data, high drives
// - write data captured at strobe falling edge
// - all cycle inputs sampled at falling edge
// - hardware mode: valid low address, high control
// - software mode ignores address/control bus
// - segment low bits 31-0, high 63-32
// - index shows match, free or random address
// - result enable high floats page and index
// - cascade: only highest-priority device drives index, except after memory access
// - no hit: lowest device drives all ones
// - result held while strobe low, flows high
// - page outputs show configured page when enabled
// - page travels with index, same enabling
// - either chip select low selects device
// - chip selects never affect result bus
// - control decode uses code and direction
// - new entry marked valid, index driven
// - delete clears validity, index driven
// - write sets validity from line, read drives it
`default_nettype none
`include "clh_cfg.svh"

module clh_host_port (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // host cycle controls
    input wire logic strobe_n,
    input wire logic write_n,
    input wire logic select_one_n,
    input wire logic select_two_n,
    input wire logic addr_valid_n,
    input wire logic [`CLH_AC_W-1:0] addr_ctrl_bus,
    input wire logic segment_select,
    // data lines
    input wire logic [`CLH_DATA_W-1:0] data_lines_in,
    output logic [`CLH_DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    // entry validity line
    input wire logic entry_valid_n_in,
    output logic entry_valid_n_out,
    output logic entry_valid_n_oe,
    // result bus and cascade
    input wire logic result_drive_n,
    input wire logic above_claims_n,
    input wire logic lowest_device,
    output logic [`CLH_IDX_W-1:0] active_index_bus,
    output logic [`CLH_PAGE_W-1:0] bank_number_out,
    output logic result_oe,
    // configuration straps
    input wire logic [`CLH_PAGE_W-1:0] bank_number_cfg,
    input wire logic sw_control
);
    import clh_pkg::*;

    // ==========================================
    // helpers
    function automatic clh_op_t clh_decode(input logic [`CLH_CODE_W-1:0] code, input logic wr_n);
        clh_op_t op;
        op = CLH_OP_NONE;
        case (code)
            `CLH_CODE_COMPARAND: op = wr_n ? CLH_OP_CMP_READ : CLH_OP_CMP_LOAD;
            `CLH_CODE_SEARCH: op = wr_n ? CLH_OP_RD_MATCH : CLH_OP_COMPARE;
            `CLH_CODE_FREE: op = wr_n ? CLH_OP_COMPARE : CLH_OP_WR_FREE;
            `CLH_CODE_DELETE: op = wr_n ? CLH_OP_NONE : CLH_OP_DEL_MATCH;
            `CLH_CODE_AT_MATCH: op = wr_n ? CLH_OP_RD_MATCH : CLH_OP_WR_MATCH;
            default: op = CLH_OP_NONE;
        endcase
        return op;
    endfunction : clh_decode

    function automatic logic [`CLH_DATA_W-1:0] clh_half(input logic [`CLH_WORD_W-1:0] w, input logic seg);
        return seg ? w[63:32] : w[31:0];
    endfunction : clh_half

    // ==========================================
    // reset release through two flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ==========================================
    // cycle capture
    logic strobe_q;
    logic cap_fire;
    logic selected;
    clh_op_t next_op;
    clh_op_t op;
    clh_cycle_t cyc;
    logic [11:0] instr;

    assign cap_fire = strobe_q & ~strobe_n;
    assign selected = ~(select_one_n & select_two_n);

    // falling edge detect on the strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q <= 1'b1;
        end else if (clk_en) begin
            strobe_q <= strobe_n;
        end
    end

    // decode from the pins as they stand at the falling edge
    always_comb begin
        next_op = CLH_OP_NONE;
        if (!selected) begin
            next_op = CLH_OP_NONE;
        end else if (sw_control) begin
            // address/control bus unused here
            if (addr_valid_n) begin
                next_op = write_n ? CLH_OP_NONE : CLH_OP_SW_INSTR;
            end else begin
                next_op = clh_decode(instr[3:0], write_n);
            end
        end else if (!addr_valid_n) begin
            next_op = write_n ? CLH_OP_MEM_RD : CLH_OP_MEM_WR;
        end else begin
            next_op = clh_decode(addr_ctrl_bus[3:0], write_n);
        end
    end

    // sample all cycle inputs; op is a one-cycle pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc <= '0;
            op <= CLH_OP_NONE;
        end else if (clk_en) begin
            op <= cap_fire ? next_op : CLH_OP_NONE;
            if (cap_fire) begin
                cyc <= '{wr_n: write_n, seg: segment_select, vb_n: entry_valid_n_in, av_n: addr_valid_n,
                         ac: addr_ctrl_bus, data: data_lines_in};
            end
        end
    end

    // instruction register for software control
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr <= `CLH_INSTR_RESET;
        end else if (clk_en && op == CLH_OP_SW_INSTR) begin
            instr <= cyc.data[11:0];
        end
    end

    // ==========================================
    // array and comparand
    clh_arr_cmd_t arr_cmd;
    logic [`CLH_WORD_W-1:0] comparand;
    logic [`CLH_WORD_W-1:0] arr_rdata;
    logic arr_rvalid;
    logic match_hit;
    logic [`CLH_IDX_W-1:0] match_idx;
    logic free_hit;
    logic [`CLH_IDX_W-1:0] free_idx;
    logic last_hit;
    logic [`CLH_IDX_W-1:0] last_idx;

    // comparand halves follow the segment select
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            comparand <= `CLH_WORD_RESET;
        end else if (clk_en && op == CLH_OP_CMP_LOAD) begin
            if (cyc.seg) begin
                comparand[63:32] <= cyc.data;
            end else begin
                comparand[31:0] <= cyc.data;
            end
        end
    end

    // steer the array from the decoded op
    always_comb begin
        arr_cmd = '0;
        arr_cmd.wdata = {cyc.data, cyc.data};
        case (op)
            CLH_OP_MEM_WR: begin
                arr_cmd.addr = cyc.ac;
                arr_cmd.we_lo = ~cyc.seg;
                arr_cmd.we_hi = cyc.seg;
                arr_cmd.val_we = 1'b1;
                arr_cmd.val = ~cyc.vb_n;
            end
            CLH_OP_MEM_RD: begin
                arr_cmd.addr = cyc.ac;
                arr_cmd.rd = 1'b1;
            end
            CLH_OP_WR_FREE: begin
                // whole comparand goes in as a new valid entry
                arr_cmd.addr = free_idx;
                arr_cmd.wdata = comparand;
                arr_cmd.we_lo = free_hit;
                arr_cmd.we_hi = free_hit;
                arr_cmd.val_we = free_hit;
                arr_cmd.val = 1'b1;
            end
            CLH_OP_DEL_MATCH: begin
                arr_cmd.addr = last_idx;
                arr_cmd.val_we = last_hit;
                arr_cmd.val = 1'b0;
            end
            CLH_OP_WR_MATCH: begin
                arr_cmd.addr = last_idx;
                arr_cmd.we_lo = last_hit & ~cyc.seg;
                arr_cmd.we_hi = last_hit & cyc.seg;
            end
            CLH_OP_RD_MATCH: begin
                arr_cmd.addr = last_idx;
                arr_cmd.rd = 1'b1;
            end
            default: arr_cmd = '0;
        endcase
    end

    clh_array u_array (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .cmd(arr_cmd),
        .comparand(comparand),
        .rdata(arr_rdata),
        .rvalid(arr_rvalid),
        .match_hit(match_hit),
        .match_idx(match_idx),
        .free_hit(free_hit),
        .free_idx(free_idx)
    );

    // ==========================================
    // read path: array answers a cycle after the op
    clh_op_t rd_op;
    logic rd_seg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_op <= CLH_OP_NONE;
            rd_seg <= 1'b0;
        end else if (clk_en) begin
            rd_op <= (op == CLH_OP_MEM_RD || op == CLH_OP_RD_MATCH || op == CLH_OP_CMP_READ) ? op : CLH_OP_NONE;
            rd_seg <= cyc.seg;
        end
    end

    // drive only in a selected read cycle while the strobe is low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_lines_out <= `CLH_DATA_RESET;
            data_lines_oe <= 1'b0;
            entry_valid_n_out <= 1'b1;
            entry_valid_n_oe <= 1'b0;
        end else if (clk_en) begin
            if (strobe_n) begin
                data_lines_oe <= 1'b0;
                entry_valid_n_oe <= 1'b0;
            end else if (rd_op != CLH_OP_NONE) begin
                data_lines_oe <= 1'b1;
                if (rd_op == CLH_OP_CMP_READ) begin
                    data_lines_out <= clh_half(comparand, rd_seg);
                end else begin
                    data_lines_out <= clh_half(arr_rdata, rd_seg);
                    entry_valid_n_out <= ~arr_rvalid;
                    entry_valid_n_oe <= 1'b1;
                end
            end
        end
    end

    // ==========================================
    // result shadow, then the strobe latch
    logic [`CLH_IDX_W-1:0] sh_idx;
    logic sh_hit;
    logic sh_prio;
    logic res_hit;
    logic res_prio;
    logic next_result_oe;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_idx <= `CLH_IDX_RESET;
            sh_hit <= 1'b0;
            sh_prio <= 1'b0;
            last_hit <= 1'b0;
            last_idx <= `CLH_IDX_RESET;
        end else if (clk_en) begin
            case (op)
                CLH_OP_MEM_WR, CLH_OP_MEM_RD: begin
                    sh_idx <= cyc.ac;
                    sh_hit <= 1'b1;
                    sh_prio <= 1'b0;
                end
                CLH_OP_COMPARE: begin
                    sh_idx <= match_idx;
                    sh_hit <= match_hit;
                    sh_prio <= 1'b1;
                    last_idx <= match_idx;
                    last_hit <= match_hit;
                end
                CLH_OP_WR_FREE: begin
                    sh_idx <= free_idx;
                    sh_hit <= free_hit;
                    sh_prio <= 1'b1;
                end
                CLH_OP_DEL_MATCH, CLH_OP_WR_MATCH, CLH_OP_RD_MATCH: begin
                    sh_idx <= last_idx;
                    sh_hit <= last_hit;
                    sh_prio <= 1'b1;
                end
                default: sh_idx <= sh_idx;
            endcase
        end
    end

    // transparent while the strobe is high, held while low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_index_bus <= `CLH_IDX_RESET;
            bank_number_out <= '0;
            res_hit <= 1'b0;
            res_prio <= 1'b0;
        end else if (clk_en && strobe_n) begin
            active_index_bus <= (sh_prio && !sh_hit) ? `CLH_IDX_ALL_ONES : sh_idx;
            bank_number_out <= bank_number_cfg;
            res_hit <= sh_hit;
            res_prio <= sh_prio;
        end
    end

    // chip selects deliberately absent from this term
    always_comb begin
        if (result_drive_n) begin
            next_result_oe = 1'b0;
        end else if (!res_prio) begin
            next_result_oe = 1'b1;
        end else if (res_hit) begin
            next_result_oe = above_claims_n;
        end else begin
            next_result_oe = above_claims_n & lowest_device;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_oe <= 1'b0;
        end else if (clk_en) begin
            result_oe <= next_result_oe;
        end
    end

    // ==========================================
    // checks
    // only reads that decode to a real operation turn the lines round
    sequence s_read_fall;
        cap_fire && selected && write_n && clk_en && next_op != CLH_OP_NONE;
    endsequence

    sequence s_low_hold;
        (!strobe_n && clk_en) [*3];
    endsequence

    chk_float_high: assert property (@(posedge core_clk) disable iff (!rst_n)
        strobe_n && $past(strobe_n) |-> !data_lines_oe && !entry_valid_n_oe)
        else $error("data lines driven while strobe high");

    chk_read_drives: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_fall ##0 s_low_hold |=> data_lines_oe)
        else $error("read cycle did not drive data lines");

    chk_write_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_fire && !write_n && clk_en |=> !data_lines_oe [*2])
        else $error("write cycle drove data lines");

    chk_capture_data: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_fire && clk_en |=> cyc.data == $past(data_lines_in) && cyc.seg == $past(segment_select))
        else $error("cycle inputs not captured at falling edge");

    chk_unselected_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_fire && !selected && clk_en |=> arr_cmd == '0 ##1 rd_op == CLH_OP_NONE)
        else $error("unselected cycle acted");

    chk_sw_ignores_ac: assert property (@(posedge core_clk) disable iff (!rst_n)
        cap_fire && clk_en && sw_control && !addr_valid_n && selected
            |=> op == clh_decode(instr[3:0], cyc.wr_n))
        else $error("software mode used address/control bus");

    chk_result_float: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(result_drive_n) && $past(clk_en) |-> !result_oe)
        else $error("result bus driven while disabled");

    chk_result_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(!strobe_n) |-> $stable(active_index_bus) && $stable(bank_number_out))
        else $error("result bus changed while strobe low");

    chk_page_value: assert property (@(posedge core_clk) disable iff (!rst_n)
        $past(strobe_n && clk_en && rst_n) |-> bank_number_out == $past(bank_number_cfg))
        else $error("page outputs differ from configured page");

    chk_miss_ones: assert property (@(posedge core_clk) disable iff (!rst_n)
        result_oe && res_prio && !res_hit |-> active_index_bus == `CLH_IDX_ALL_ONES && lowest_device || !$stable(lowest_device))
        else $error("miss result not all ones");

endmodule : clh_host_port

`default_nettype wire

// ### clh_bus_model.sv
`default_nettype none
`include "clh_cfg.svh"

// ==========================================
// host pads: resolves the shared lines
module clh_bus_model (
    // clock
    input wire logic core_clk,
    // host side
    input wire logic [`CLH_DATA_W-1:0] host_dq,
    input wire logic host_vb_n,
    input wire logic host_oe,
    // device side
    input wire logic [`CLH_DATA_W-1:0] dev_dq,
    input wire logic dev_dq_oe,
    input wire logic dev_vb_n,
    input wire logic dev_vb_oe,
    // resolved lines
    output logic [`CLH_DATA_W-1:0] dq,
    output logic vb_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`CLH_DATA_W-1:0] last_dq = '0;
    logic last_vb = 1'b0;
    // no pull on these lines, so a released line shows a moving pattern
    assign dq = dev_dq_oe ? dev_dq : host_oe ? host_dq : ~last_dq;
    assign vb_n = dev_vb_oe ? dev_vb_n : host_oe ? host_vb_n : ~last_vb;
    // line history
    always @(posedge core_clk) begin
        last_dq <= dq;
        last_vb <= vb_n;
    end
endmodule : clh_bus_model

`default_nettype wire

// ### cam_lookup_host_bus_interface_test.sv
`default_nettype none
`include "clh_cfg.svh"

module cam_lookup_host_bus_interface_test;
    timeunit 1ns;
    timeprecision 1ns;
    import clh_pkg::*;
    // ==========================================
    // pins
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic strobe_n = 1'b1;
    logic [1:0] sel_n = 2'b11;
    logic drive_n = 1'b0;
    logic above_n = 1'b1;
    logic lowest = 1'b1;
    logic sw_mode = 1'b0;
    logic host_oe = 1'b0;
    logic [3:0] bank_cfg = 4'h0;
    clh_cycle_t cyc = '0;
    logic [31:0] dq, dq_out, rd;
    logic vb_n, vb_out, dq_oe, vb_oe, res_oe, rvb;
    logic [11:0] idx;
    logic [3:0] bank;
    logic [31:0] seed = 32'h19190773;
    int err_count = 0;
    int comparisons = 0;

    always #50 core_clk = ~core_clk;

    clh_host_port clh_host_port_i (
        .core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .strobe_n(strobe_n),
        .write_n(cyc.wr_n), .select_one_n(sel_n[1]), .select_two_n(sel_n[0]),
        .addr_valid_n(cyc.av_n), .addr_ctrl_bus(cyc.ac), .segment_select(cyc.seg),
        .data_lines_in(dq), .data_lines_out(dq_out), .data_lines_oe(dq_oe),
        .entry_valid_n_in(vb_n), .entry_valid_n_out(vb_out), .entry_valid_n_oe(vb_oe),
        .result_drive_n(drive_n), .above_claims_n(above_n), .lowest_device(lowest),
        .active_index_bus(idx), .bank_number_out(bank), .result_oe(res_oe),
        .bank_number_cfg(bank_cfg), .sw_control(sw_mode)
    );

    clh_bus_model clh_bus_model_i (
        .core_clk(core_clk), .host_dq(cyc.data), .host_vb_n(cyc.vb_n), .host_oe(host_oe),
        .dev_dq(dq_out), .dev_dq_oe(dq_oe), .dev_vb_n(vb_out), .dev_vb_oe(vb_oe),
        .dq(dq), .vb_n(vb_n)
    );

    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // losers of the cascade float whatever the enable says
    function automatic logic exp_oe(input logic cas, input logic hit);
        return !drive_n && (!cas || (above_n && (hit || lowest)));
    endfunction : exp_oe

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_val(what, {31'h0, exp}, {31'h0, got});
    endtask : check_bit

    task automatic res_chk(input logic cas, input logic hit, input logic [11:0] a);
        check_bit("result enable", exp_oe(cas, hit), res_oe);
        if (exp_oe(cas, hit)) begin
            check_val("index", {20'h0, hit ? a : 12'hfff}, {20'h0, idx});
            check_val("bank", {28'h0, bank_cfg}, {28'h0, bank});
        end
    endtask : res_chk

    // ctl is {write_n, addr_valid_n, segment, validity_n}; all held from set-up to release
    task automatic hc(input logic [3:0] ctl, input logic [11:0] ac, input logic [31:0] d, input logic [1:0] s);
        logic [11:0] held;
        @(negedge core_clk);
        cyc = '{wr_n: ctl[3], av_n: ctl[2], seg: ctl[1], vb_n: ctl[0], ac: ac, data: d};
        sel_n = s;
        host_oe = !ctl[3];
        repeat (2) @(negedge core_clk);
        held = idx;
        strobe_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rd = dq;
        rvb = vb_n;
        check_bit("data drive", ctl[3] & ~&s, dq_oe);
        check_val("held index", {20'h0, held}, {20'h0, idx});
        @(negedge core_clk);
        strobe_n = 1'b1;
        repeat (2) @(negedge core_clk);
        check_bit("data float", 1'b0, dq_oe);
        host_oe = 1'b0;
    endtask : hc

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] lo, hi, x;
        logic [63:0] w0;
        logic [11:0] a, a0;
        x = rnd();
        bank_cfg = x[3:0];
        repeat (10) @(negedge core_clk);
        check_bit("drive in reset", 1'b0, dq_oe);
        repeat (10) @(negedge core_clk);
        resetn = 1'b1;
        repeat (4) @(negedge core_clk);
        // random words; addresses kept off the lowest slots for the free search
        for (int i = 0; i < 4; i++) begin
            x = rnd();
            a = x[11:0] | 12'h010;
            lo = rnd();
            hi = rnd();
            hc({3'b000, i[0]}, a, lo, 2'b01);
            hc({3'b001, i[0]}, a, hi, 2'b10);
            hc(4'h8, a, 32'h0, 2'b00);
            check_val("low half", lo, rd);
            check_bit("validity", i[0], rvb);
            hc(4'ha, a, 32'h0, 2'b00);
            check_val("high half", hi, rd);
            res_chk(1'b0, 1'b1, a);
            hc(4'h0, a, ~lo, 2'b11);
            hc(4'h8, a, 32'h0, 2'b11);
            res_chk(1'b0, 1'b1, a);
            hc(4'h8, a, 32'h0, 2'b00);
            check_val("unselected write", lo, rd);
            if (i == 0) begin
                a0 = a;
                w0 = {hi, lo};
            end
        end
        $display("memory test done");
        // comparand, hit, cascade loser, miss
        hc(4'h4, {8'h0, `CLH_CODE_COMPARAND}, w0[31:0], 2'b00);
        hc(4'h6, {8'h0, `CLH_CODE_COMPARAND}, w0[63:32], 2'b00);
        hc(4'he, {8'h0, `CLH_CODE_COMPARAND}, 32'h0, 2'b00);
        check_val("comparand high", w0[63:32], rd);
        hc(4'h4, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b1, a0);
        above_n = 1'b0;
        hc(4'h4, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b1, a0);
        above_n = 1'b1;
        hc(4'h4, {8'h0, `CLH_CODE_COMPARAND}, ~w0[31:0], 2'b00);
        hc(4'h4, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b0, a0);
        lowest = 1'b0;
        hc(4'h4, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b0, a0);
        lowest = 1'b1;
        drive_n = 1'b1;
        repeat (3) @(negedge core_clk);
        check_bit("result enable off", 1'b0, res_oe);
        drive_n = 1'b0;
        $display("compare test done");
        // delete the hit, then next-free lands in slot zero
        hc(4'h4, {8'h0, `CLH_CODE_COMPARAND}, w0[31:0], 2'b00);
        hc(4'h4, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        hc(4'h4, {8'h0, `CLH_CODE_DELETE}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b1, a0);
        hc(4'h8, a0, 32'h0, 2'b00);
        check_bit("deleted validity", 1'b1, rvb);
        hc(4'h4, {8'h0, `CLH_CODE_FREE}, 32'h0, 2'b00);
        res_chk(1'b1, 1'b1, 12'h000);
        hc(4'ha, 12'h000, 32'h0, 2'b00);
        check_val("free word", w0[63:32], rd);
        check_bit("free validity", 1'b0, rvb);
        // last match still points at the deleted slot: write then read there
        hc(4'h4, {8'h0, `CLH_CODE_AT_MATCH}, ~lo, 2'b00);
        hc(4'hc, {8'h0, `CLH_CODE_SEARCH}, 32'h0, 2'b00);
        check_val("match word", ~lo, rd);
        res_chk(1'b1, 1'b1, a0);
        $display("entry test done");
        // software mode: address bus carries junk and must not matter
        sw_mode = 1'b1;
        hc(4'h4, 12'h000, {28'h0, `CLH_CODE_COMPARAND}, 2'b00);
        x = rnd();
        hc(4'h0, x[11:0], ~x, 2'b00);
        hc(4'h8, ~x[11:0], 32'h0, 2'b00);
        check_val("soft comparand", ~x, rd);
        sw_mode = 1'b0;
        $display("software test done");
        print_verdict();
    end

    // watchdog: forty-seven cycles of ten clocks each, wide margin
    initial begin
        #2000000;
        err_count++;
        print_verdict();
    end
endmodule : cam_lookup_host_bus_interface_test

`default_nettype wire
